// >>> design/sssc_pkg.sv
// Purpose: shared constants for the spi slave shift control block
// Assumes: one system clock, link signals sampled as plain inputs
// Notes: widths and counts live here so every importing file agrees
package sssc_pkg;
    localparam int SSSC_DATA_W = 8;
    localparam int SSSC_CNT_W = 4;
    localparam logic [7:0] SSSC_DATA_RST = 8'h00;
    localparam logic [3:0] SSSC_EDGES_PER_BYTE = 4'h0;
    localparam logic [1:0] SSSC_SYNC_RST = 2'h3;
    localparam logic [1:0] SSSC_SCK_SYNC_RST = 2'h0;
endpackage

// >>> design/sssc_sync.sv
// Purpose: two-flop synchronisers for the four link inputs
// Assumes: inputs asynchronous to clk
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module sssc_sync
    import sssc_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic sck_in,
    input wire logic sel_n_in,
    input wire logic mosi_in,
    input wire logic miso_in,
    sssc_sync_if.src sy
);
    logic [1:0] sck_q;
    logic [1:0] sel_q;
    logic [1:0] mosi_q;
    logic [1:0] miso_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sck_q <= SSSC_SCK_SYNC_RST;
            sel_q <= SSSC_SYNC_RST;
            mosi_q <= SSSC_SYNC_RST;
            miso_q <= SSSC_SYNC_RST;
        end else begin
            sck_q <= {sck_q[0], sck_in};
            sel_q <= {sel_q[0], sel_n_in};
            mosi_q <= {mosi_q[0], mosi_in};
            miso_q <= {miso_q[0], miso_in};
        end
    end

    assign sy.sck_s = sck_q[1];
    assign sy.sel_n_s = sel_q[1];
    assign sy.mosi_s = mosi_q[1];
    assign sy.miso_s = miso_q[1];
endmodule

// >>> design/sssc_sync_if.sv
// Purpose: carries synchronised link levels into the main block
// Assumes: all members are on the clk domain
// Notes: filled by sssc_sync, read by sssc_top
`timescale 1ns/1ps
interface sssc_sync_if;
    logic sck_s;
    logic sel_n_s;
    logic mosi_s;
    logic miso_s;
    modport src (output sck_s, output sel_n_s, output mosi_s, output miso_s);
    modport dst (input sck_s, input sel_n_s, input mosi_s, input miso_s);
endinterface

// >>> design/sssc_top.sv
// Purpose: slave-side shift control of a serial peripheral interface
// Assumes: external master makes the serial clock; link edges are
//          found by oversampling with clk, so sck must be slow
// Notes: master clock generation is not part of this block
`timescale 1ns/1ps
module sssc_top
    import sssc_pkg::*;
#(
    parameter int DATA_W = SSSC_DATA_W
) (
    input wire logic clk,
    input wire logic sys_rst,
    // configuration
    input wire logic master_select_bit,
    input wire logic serial_pin_control_bit,
    input wire logic bidir_output_enable,
    input wire logic clock_phase_bit,
    input wire logic clock_polarity_bit,
    input wire logic lsb_first_enable,
    input wire logic select_output_enable,
    input wire logic mode_fault_enable,
    // transmit data load and received data
    input wire logic tx_load,
    input wire logic [DATA_W-1:0] tx_data,
    output logic [DATA_W-1:0] rx_data,
    output logic transfer_done_flag,
    input wire logic done_clear,
    output logic mode_fault_flag,
    input wire logic status_read,
    input wire logic ctrl1_write,
    output logic slave_active,
    output logic busy,
    // link pins
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    input wire logic sel_n_in,
    output logic sel_n_out,
    output logic sel_n_oe,
    input wire logic mosi_in,
    output logic mosi_out,
    output logic mosi_oe,
    input wire logic miso_in,
    output logic miso_out,
    output logic miso_oe
);
    import sssc_pkg::*;

    // ------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------
    sssc_sync_if sy ();

    sssc_sync u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .sck_in(sck_in),
        .sel_n_in(sel_n_in),
        .mosi_in(mosi_in),
        .miso_in(miso_in),
        .sy(sy)
    );

    // ------------------------------------------------------------
    // mode and select
    // ------------------------------------------------------------
    logic sck_d1_q;
    logic sel_d1_q;
    logic fault_q;
    logic fault_armed_q;
    logic is_slave;
    logic selected;
    logic sck_edge;
    logic sel_rise;

    // slave when clear or forced by fault
    assign is_slave = !master_select_bit || fault_q;
    assign selected = is_slave && !sy.sel_n_s;
    assign sck_edge = selected && (sy.sck_s != sck_d1_q);
    assign sel_rise = sy.sel_n_s && !sel_d1_q;

    // reset levels match the synchroniser resets: no false edge
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sck_d1_q <= 1'b0;
            sel_d1_q <= 1'b1;
        end else begin
            sck_d1_q <= sy.sck_s;
            sel_d1_q <= sy.sel_n_s;
        end
    end

    // ------------------------------------------------------------
    // shift engine
    // ------------------------------------------------------------
    typedef enum logic [0:0] {SSSC_IDLE, SSSC_XFER} sssc_state_e;
    sssc_state_e state_q;
    logic [SSSC_CNT_W-1:0] edge_q;
    logic [DATA_W-1:0] shift_q;
    logic [DATA_W-1:0] data_q;
    logic latch_q;
    logic out_bit_q;
    logic din;
    logic odd_edge;
    logic sample_now;
    logic shift_now;
    logic last_shift;
    logic first_edge;
    logic [DATA_W-1:0] shift_next;
    logic [DATA_W-1:0] shift_din;
    logic [DATA_W-1:0] byte_in;

    assign din = serial_pin_control_bit ? miso_in_s() : sy.mosi_s;

    function automatic logic miso_in_s();
        return sy.miso_s;
    endfunction

    // edge_q counts edges already seen; next edge is edge_q+1
    assign odd_edge = !edge_q[0];
    // phase picks sample and shift edges
    assign sample_now = sck_edge && (clock_phase_bit ? !odd_edge : odd_edge);
    // phase set: edge one only presents data, nothing to shift yet
    assign first_edge = edge_q == SSSC_EDGES_PER_BYTE;
    assign shift_now = sck_edge && (clock_phase_bit ? odd_edge : !odd_edge)
        && !(clock_phase_bit && first_edge);
    assign last_shift = sck_edge && !odd_edge
        && edge_q == SSSC_CNT_W'(2 * DATA_W - 1);

    always_comb begin
        if (lsb_first_enable) begin
            shift_next = {latch_q, shift_q[DATA_W-1:1]};
            shift_din = {din, shift_q[DATA_W-1:1]};
        end else begin
            shift_next = {shift_q[DATA_W-2:0], latch_q};
            shift_din = {shift_q[DATA_W-2:0], din};
        end
    end

    // phase set: the last bit is sampled on the final edge and no
    // shift edge follows, so it goes in straight from the pin
    assign byte_in = clock_phase_bit ? shift_din : shift_next;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= SSSC_IDLE;
            edge_q <= '0;
        end else if (!selected || sel_rise) begin
            state_q <= SSSC_IDLE;
            edge_q <= '0;
        end else if (sck_edge) begin
            state_q <= last_shift ? SSSC_IDLE : SSSC_XFER;
            edge_q <= last_shift ? '0 : edge_q + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            latch_q <= 1'b0;
        end else if (sample_now) begin
            latch_q <= din;
        end
    end

    // shift register holds tx byte until edges move it
    // a load while busy is dropped: it would corrupt the byte
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            shift_q <= SSSC_DATA_RST;
        end else if (last_shift) begin
            shift_q <= byte_in;
        end else if (shift_now) begin
            shift_q <= shift_next;
        end else if (tx_load && state_q == SSSC_IDLE) begin
            shift_q <= tx_data;
        end
    end

    // byte copied, flag set wins over clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            data_q <= SSSC_DATA_RST;
            transfer_done_flag <= 1'b0;
        end else begin
            if (last_shift) begin
                data_q <= byte_in;
            end
            if (last_shift) begin
                transfer_done_flag <= 1'b1;
            end else if (done_clear) begin
                transfer_done_flag <= 1'b0;
            end
        end
    end
    assign rx_data = data_q;

    // ------------------------------------------------------------
    // serial output
    // ------------------------------------------------------------
    // the bit on the pin is the end that leaves first
    logic first_bit;
    assign first_bit = lsb_first_enable ? shift_q[0] : shift_q[DATA_W-1];

    // first bit presented at select or edge one
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            out_bit_q <= 1'b0;
        end else if (!clock_phase_bit || !first_edge || sck_edge) begin
            out_bit_q <= first_bit;
        end
    end

    // enable is combinational so the pin lets go as select rises
    // drive only while selected
    logic drive;
    assign drive = selected && !fault_q;

    // pin roles by pin control and bidir
    always_comb begin
        miso_out = out_bit_q;
        mosi_out = out_bit_q;
        miso_oe = 1'b0;
        mosi_oe = 1'b0;
        if (serial_pin_control_bit) begin
            miso_oe = drive && bidir_output_enable;
        end else begin
            miso_oe = drive;
        end
    end

    // clock and select never driven here
    assign sck_out = clock_polarity_bit;
    assign sck_oe = 1'b0;
    assign sel_n_out = 1'b1;
    assign sel_n_oe = 1'b0;

    // ------------------------------------------------------------
    // mode fault
    // ------------------------------------------------------------
    // a slave never sees a fault; its select is only an input
    logic fault_event;
    assign fault_event = master_select_bit && mode_fault_enable
        && !sy.sel_n_s;

    // master-only fault, read then write clears
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fault_q <= 1'b0;
            fault_armed_q <= 1'b0;
        end else begin
            // set wins over a clear in the same cycle
            if (fault_event) begin
                fault_q <= 1'b1;
                fault_armed_q <= 1'b0;
            end else if (fault_armed_q && ctrl1_write) begin
                fault_q <= 1'b0;
                fault_armed_q <= 1'b0;
            end else if (status_read && fault_q) begin
                fault_armed_q <= 1'b1;
            end
        end
    end
    assign mode_fault_flag = fault_q;

    // ------------------------------------------------------------
    // status
    // ------------------------------------------------------------
    // busy drops one clk after the synchronised deselect, so software can poll it
    assign slave_active = is_slave;
    assign busy = state_q == SSSC_XFER;
endmodule

// >>> dv/sssc_chk.sv
// Purpose: port checks of the slave shift control
// Assumes: link pins are asynchronous and sampled by clk
// Notes: bound from the test top
`timescale 1ns/1ps
module sssc_chk #(
    parameter int DATA_W = 8
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic master_select_bit,
    input wire logic serial_pin_control_bit,
    input wire logic bidir_output_enable,
    input wire logic [DATA_W-1:0] rx_data,
    input wire logic transfer_done_flag,
    input wire logic done_clear,
    input wire logic mode_fault_flag,
    input wire logic busy,
    input wire logic sck_oe,
    input wire logic sel_n_in,
    input wire logic sel_n_oe,
    input wire logic miso_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    clk_pin_in_a: assert property (
        !master_select_bit |-> !sck_oe) else $error("sck driven");
    sel_pin_in_a: assert property (
        !master_select_bit |-> !sel_n_oe) else $error("select driven");
    // four cycles covers the two sync flops
    miso_tristate_a: assert property (
        sel_n_in [*4] |-> !miso_oe) else $error("miso driven");
    idle_on_sel_a: assert property (
        sel_n_in [*4] |-> !busy) else $error("busy while deselected");
    rx_stable_a: assert property (
        sel_n_in [*4] |=> $stable(rx_data)) else $error("rx moved");
    bidir_off_a: assert property (
        serial_pin_control_bit && !bidir_output_enable |-> !miso_oe)
        else $error("pin driven");
    no_slave_fault_a: assert property (
        $rose(mode_fault_flag) |-> $past(master_select_bit))
        else $error("fault in slave");
    slave_no_fault_a: assert property (
        !master_select_bit && !mode_fault_flag |=> !mode_fault_flag)
        else $error("fault raised in slave");
    done_hold_a: assert property (
        transfer_done_flag && !done_clear |=> transfer_done_flag)
        else $error("flag dropped");
    rx_with_flag_a: assert property (
        $changed(rx_data) |-> ##[0:1] transfer_done_flag)
        else $error("rx without flag");
    cover property ($rose(transfer_done_flag));
    cover property (busy ##1 $rose(sel_n_in));
    cover property (serial_pin_control_bit && miso_oe);
endmodule

// >>> dv/sssc_master.sv
// Purpose: behavioural serial master driving the link pins
// Assumes: half period 62.5 ns, clock stands still outside frames
// Notes: released data line shows the inverse of its last bit
`timescale 1ns/1ps
module sssc_master (
    output logic sck,
    output logic sel_n,
    output logic mosi,
    input wire logic miso
);
    logic [7:0] q;
    initial begin
        sck = 1'b0;
        sel_n = 1'b1;
        mosi = 1'b0;
    end
    task automatic put(input logic lsbf);
        mosi = lsbf ? q[0] : q[7];
        q = lsbf ? q >> 1 : q << 1;
    endtask
    task automatic xfer(input logic pol, input logic pha,
            input logic lsbf, input logic [7:0] d, input int n,
            output logic [7:0] r);
        r = 8'h00;
        q = d;
        sck = pol;
        // idle level settles first so selecting makes no false edge
        #62.5;
        // select low before first edge, held to the end
        sel_n = 1'b0;
        if (!pha) put(lsbf);
        #125;
        for (int e = 1; e <= n; e++) begin
            sck = ~sck;
            if (e % 2 != int'(pha)) r = lsbf ? {miso, r[7:1]} : {r[6:0], miso};
            else put(lsbf);
            #62.5;
        end
        sel_n = 1'b1;
        mosi = ~mosi;
        #62.5 sck = pol;
        #190;
    endtask
endmodule

// >>> dv/sssc_top_test.sv
// Purpose: self-checking bench of the slave shift control
// Assumes: one partner master, slave mode throughout
// Notes: table rows cover all phase, polarity and order modes
`timescale 1ns/1ps
module sssc_top_test;
    import sssc_pkg::*;
    typedef struct packed {
        logic pol, pha, lsb;
        logic [7:0] tx, mo;
    } sssc_row_s;
    logic clk, sys_rst, master_select_bit, serial_pin_control_bit;
    logic bidir_output_enable, clock_phase_bit, clock_polarity_bit;
    logic lsb_first_enable, select_output_enable, mode_fault_enable;
    logic tx_load, done_clear, status_read, ctrl1_write;
    logic [7:0] tx_data, rx_data, got;
    logic transfer_done_flag, mode_fault_flag, slave_active, busy;
    logic sck_out, sck_oe, sel_n_out, sel_n_oe, mosi_out, mosi_oe;
    logic miso_out, miso_oe;
    logic miso_hold = 1'b0;
    wire sck_in, sel_n_in, mosi_in, miso_in;
    int miscompares = 0, n_checks = 0;
    sssc_row_s rows [5] = '{'{0, 0, 0, 8'ha5, 8'h3c},
        '{0, 1, 0, 8'h81, 8'h7e}, '{1, 0, 1, 8'h01, 8'hc3},
        '{1, 1, 1, 8'h80, 8'h5a}, '{0, 0, 1, 8'hff, 8'h00}};
    // the slave drives it when enabled; else mosi in single-pin mode, else the inverse of its last bit
    assign miso_in = miso_oe ? miso_out
        : serial_pin_control_bit ? mosi_in : ~miso_hold;
    always @(posedge clk) if (miso_oe) miso_hold <= miso_out;
    sssc_top #(.DATA_W(SSSC_DATA_W)) uut (
        .clk, .sys_rst, .master_select_bit, .serial_pin_control_bit,
        .bidir_output_enable, .clock_phase_bit, .clock_polarity_bit,
        .lsb_first_enable, .select_output_enable, .mode_fault_enable,
        .tx_load, .tx_data, .rx_data, .transfer_done_flag, .done_clear,
        .mode_fault_flag, .status_read, .ctrl1_write, .slave_active, .busy,
        .sck_in, .sck_out, .sck_oe, .sel_n_in, .sel_n_out, .sel_n_oe,
        .mosi_in, .mosi_out, .mosi_oe, .miso_in, .miso_out, .miso_oe);
    sssc_master m (.sck(sck_in), .sel_n(sel_n_in), .mosi(mosi_in),
        .miso(miso_in));
    task automatic check(input logic [7:0] s, input logic [7:0] e);
        n_checks++;
        if (s !== e) begin
            miscompares++;
            $display("BAD %0t seen %h want %h", $time, s, e);
        end
    endtask
    task automatic end_sim;
        if (miscompares == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic pulse(ref logic s);
        @(negedge clk) s = 1'b1;
        @(negedge clk) s = 1'b0;
    endtask
    task automatic run(input sssc_row_s r, input int n);
        @(negedge clk) {clock_polarity_bit, clock_phase_bit} = {r.pol, r.pha};
        lsb_first_enable = r.lsb;
        tx_data = r.tx;
        pulse(tx_load);
        m.xfer(r.pol, r.pha, r.lsb, r.mo, n, got);
        repeat (4) @(negedge clk);
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #200000;
        miscompares++;
        end_sim();
    end
    initial begin
        {master_select_bit, serial_pin_control_bit, bidir_output_enable} =
            3'h0;
        {clock_phase_bit, clock_polarity_bit, lsb_first_enable} = 3'h0;
        {select_output_enable, mode_fault_enable, status_read} = 3'h0;
        {tx_load, done_clear, ctrl1_write, tx_data} = 11'h000;
        sys_rst = 1'b1;
        repeat (12) @(negedge clk);
        sys_rst = 1'b0;
        @(negedge clk);
        check(rx_data, SSSC_DATA_RST);
        check({4'h0, transfer_done_flag, mode_fault_flag, miso_oe, busy},
            8'h00);
        check({4'h0, sck_oe, sel_n_oe, mosi_oe, slave_active},
            8'h01);
        mode_fault_enable = 1'b1;
        foreach (rows[i]) begin
            pulse(done_clear);
            run(rows[i], 16);
            check(rx_data, rows[i].mo);
            check(got, rows[i].tx);
            check({7'h0, transfer_done_flag}, 8'h01);
        end
        pulse(status_read);
        pulse(ctrl1_write);
        check({7'h0, mode_fault_flag}, 8'h00);
        pulse(done_clear);
        run(rows[1], 7);
        check({6'h0, transfer_done_flag, busy}, 8'h00);
        repeat (4) #62.5 m.sck = ~m.sck;
        #100;
        check(rx_data, rows[4].mo);
        run(rows[0], 16);
        check(rx_data, rows[0].mo);
        check(got, rows[0].tx);
        for (int b = 0; b < 2; b++) begin
            @(negedge clk) {serial_pin_control_bit, bidir_output_enable} =
                {1'b1, b[0]};
            fork
                m.xfer(1'b0, 1'b0, 1'b0, 8'h00, 0, got);
                #100 check({7'h0, miso_oe}, {7'h0, b[0]});
            join
        end
        @(negedge clk) bidir_output_enable = 1'b0;
        // single-pin slave: the master's data arrives on the shared pin
        run(rows[3], 16);
        check(rx_data, rows[3].mo);
        end_sim();
    end
endmodule
bind sssc_top sssc_chk #(.DATA_W(DATA_W)) chk (.clk, .sys_rst,
    .master_select_bit, .serial_pin_control_bit, .bidir_output_enable,
    .rx_data, .transfer_done_flag, .done_clear, .mode_fault_flag, .busy,
    .sck_oe, .sel_n_in, .sel_n_oe, .miso_oe);
